// file: shared/dmb_pkg.sv
// Constants and types for the debug-mode bus arbiter and power-cut control
package dmb_pkg;
	localparam logic [11:0] PCC_OFFSET      = 12'h2f0;
	localparam logic [11:0] PORTCTL_OFFSET  = 12'h2f4;
	localparam logic [11:0] STATUS_OFFSET   = 12'h2f8;
	localparam int          PCC_ON_BIT      = 7;
	localparam int          PCC_WO_BIT      = 2;
	localparam int          PCC_WU_LSB      = 0;
	localparam logic [7:0]  PCC_RESET       = 8'h00;
	localparam logic [7:0]  PORTCTL_RESET   = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	localparam int          WU_BASE_EXP     = 9;
	localparam int          STEAL_MAX_LCLK  = 80;
	localparam int          DBG_PIN_COUNT   = 9;
	typedef enum logic [3:0] {
		DMB_IDLE  = 4'b0001,
		DMB_STEAL = 4'b0010,
		DMB_DISP  = 4'b0100,
		DMB_GDMA  = 4'b1000
	} dmb_owner_t;
endpackage

// file: hw/dmb_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module dmb_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Level in and out
	input  wire logic din,
	output var  logic dout
);
	logic meta_ff;
	logic sync_ff;
	logic nxt_meta;
	logic nxt_sync;

	always_comb begin
		nxt_meta = din;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule
`default_nettype wire

// file: hw/dmb_top.sv
// Debug-mode bus arbiter, power-cut control and AXI4-Lite registers
// Contract
// - In debug mode power cut is refused; power enable stays high.
// - Power cut enable is bit 7; clears on system reset, kept on hot reset.
// - Warm-up select bits 1:0 pick 2^9..2^12 count; resets to 00.
// - Debug pin port writes store value; in debug mode pin function is unchanged.
// - Breakpoint halts only the CPU; other masters keep the bus.
// - Steal program releases the bus within 80 debug link clocks.
// - Display DMA granted before general DMA after a steal hold.
// - No preemption; a display or DMA transfer runs to completion, a steal hold until done or forced release.
// - Requests behind a pending steal wait until the steal finishes.
`timescale 1ns/1ps
`default_nettype none
module dmb_top
	import dmb_pkg::*;
#(
	parameter int STEAL_MAX = STEAL_MAX_LCLK
) (
	// Clock and resets
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        hot_resetn,
	// Device pins
	input  wire logic        debug_enable_pin_n,
	input  wire logic        boot_mode_select_0,
	input  wire logic        boot_mode_select_1,
	input  wire logic        debug_link_clock,
	// Standby request from power manager
	input  wire logic        standby_req,
	// Bus requests and done strobes
	input  wire logic        steal_req,
	input  wire logic        steal_done,
	input  wire logic        disp_req,
	input  wire logic        disp_done,
	input  wire logic        gdma_req,
	input  wire logic        gdma_done,
	input  wire logic        sdram_req,
	input  wire logic        cpu_req,
	input  wire logic        breakpoint_hit,
	// Grants and status
	output var  logic        steal_gnt,
	output var  logic        disp_gnt,
	output var  logic        gdma_gnt,
	output var  logic        sdram_gnt,
	output var  logic        cpu_gnt,
	output var  logic        cpu_halt,
	output var  logic        debug_mode,
	output var  logic        boot_allowed,
	output var  logic        power_enable_output,
	output var  logic [1:0]  warmup_sel,
	output var  logic [8:0]  dbg_pin_port_func,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic debug_enable_pin_n_s, am0_s, am1_s, lclk_s;
	dmb_sync #(.RST_VAL(1'b1)) u_s_debug_enable_pin (.aclk(aclk), .aresetn(aresetn),
		.din(debug_enable_pin_n), .dout(debug_enable_pin_n_s));
	dmb_sync #(.RST_VAL(1'b0)) u_s_am0 (.aclk(aclk), .aresetn(aresetn),
		.din(boot_mode_select_0), .dout(am0_s));
	dmb_sync #(.RST_VAL(1'b0)) u_s_am1 (.aclk(aclk), .aresetn(aresetn),
		.din(boot_mode_select_1), .dout(am1_s));
	dmb_sync #(.RST_VAL(1'b0)) u_s_lclk (.aclk(aclk), .aresetn(aresetn),
		.din(debug_link_clock), .dout(lclk_s));

	// Registers
	logic       pcc_on_ff, nxt_pcc_on;
	logic [1:0] wu_ff, nxt_wu;
	logic [7:0] portctl_ff, nxt_portctl;
	logic [8:0] pfunc_ff, nxt_pfunc;
	logic       dbg_ff, nxt_dbg;
	logic       boot_ff, nxt_boot;
	logic       pwe_ff, nxt_pwe;
	logic       refused_ff, nxt_refused;
	logic       lclk_d_ff, nxt_lclk_d;
	logic [6:0] steal_cnt_ff, nxt_steal_cnt;
	logic       steal_ovr_ff, nxt_steal_ovr;
	dmb_owner_t own_ff, nxt_own;
	logic       cpu_gnt_ff, nxt_cpu_gnt;
	logic       sdram_gnt_ff, nxt_sdram_gnt;
	logic       halt_ff, nxt_halt;
	// Bus slave state
	logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
	logic [11:0] awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic [3:0]  ws_ff, nxt_ws;
	logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;

	logic do_wr;
	logic ovr_set;
	logic lclk_rise;
	logic [7:0] pcc_read;
	assign do_wr     = aw_ff && w_ff && !bv_ff;
	assign lclk_rise = lclk_s && !lclk_d_ff;
	// Bit 2 always reads zero
	assign pcc_read  = {pcc_on_ff, 4'h0, 1'b0, wu_ff};

	always_comb begin
		nxt_dbg    = !debug_enable_pin_n_s;
		nxt_boot   = !(!debug_enable_pin_n_s && am0_s && am1_s);
		nxt_lclk_d = lclk_s;
		nxt_halt   = dbg_ff && (halt_ff || breakpoint_hit);
		if (!dbg_ff)
			nxt_halt = 1'b0;
		nxt_pcc_on  = pcc_on_ff;
		nxt_wu      = wu_ff;
		nxt_portctl = portctl_ff;
		// Hot reset keeps bit 7 but returns warm-up field to default
		if (!hot_resetn)
			nxt_wu = PCC_RESET[1:0];
		else if (do_wr && awa_ff == PCC_OFFSET && ws_ff[0]) begin
			nxt_pcc_on = wd_ff[PCC_ON_BIT];
			nxt_wu     = wd_ff[PCC_WU_LSB +: 2];
		end
		if (do_wr && awa_ff == PORTCTL_OFFSET && ws_ff[0])
			nxt_portctl = wd_ff[7:0];
		// In debug mode the pins keep the link function whatever is stored
		nxt_pfunc = dbg_ff ? '0 : {1'b0, portctl_ff};
		// Power cut only outside debug mode
		nxt_pwe     = !(pcc_on_ff && standby_req && !dbg_ff);
		nxt_refused = refused_ff || (pcc_on_ff && standby_req && dbg_ff);
		if (do_wr && awa_ff == STATUS_OFFSET && ws_ff[0] && wd_ff[0])
			nxt_refused = pcc_on_ff && standby_req && dbg_ff;
	end

	// Arbiter: no preemption, steal first, display before general DMA
	always_comb begin
		nxt_own       = own_ff;
		nxt_steal_cnt = steal_cnt_ff;
		ovr_set       = 1'b0;
		unique case (own_ff)
			DMB_IDLE: begin
				if (steal_req && dbg_ff)
					nxt_own = DMB_STEAL;
				else if (disp_req)
					nxt_own = DMB_DISP;
				else if (gdma_req)
					nxt_own = DMB_GDMA;
				nxt_steal_cnt = '0;
			end
			DMB_STEAL: begin
				if (lclk_rise)
					nxt_steal_cnt = steal_cnt_ff + 7'd1;
				// Forced release bounds the hold
				if (steal_done || !dbg_ff || (lclk_rise
					&& steal_cnt_ff == 7'(STEAL_MAX - 1))) begin
					nxt_own = DMB_IDLE;
					if (!steal_done && dbg_ff)
						ovr_set = 1'b1;
				end
			end
			DMB_DISP: if (disp_done) nxt_own = DMB_IDLE;
			DMB_GDMA: if (gdma_done) nxt_own = DMB_IDLE;
			default: nxt_own = DMB_IDLE;
		endcase
		// A forced release in the clearing cycle keeps the flag set
		nxt_steal_ovr = ovr_set || (steal_ovr_ff
			&& !(do_wr && awa_ff == STATUS_OFFSET && ws_ff[0] && wd_ff[1]));
		// Halt stops only the CPU; SDRAM refresh uses idle slots
		nxt_cpu_gnt   = cpu_req && !halt_ff && nxt_own == DMB_IDLE && !sdram_req;
		nxt_sdram_gnt = sdram_req && nxt_own == DMB_IDLE;
	end

	// AXI4-Lite slave
	always_comb begin
		nxt_aw = aw_ff; nxt_awa = awa_ff;
		nxt_w = w_ff; nxt_wd = wd_ff; nxt_ws = ws_ff;
		nxt_bv = bv_ff; nxt_br = br_ff;
		nxt_rv = rv_ff; nxt_rd = rd_ff; nxt_rr = rr_ff;
		if (s_axi_awvalid && !aw_ff) begin
			nxt_aw = 1'b1; nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_ff) begin
			nxt_w = 1'b1; nxt_wd = s_axi_wdata; nxt_ws = s_axi_wstrb;
		end
		if (do_wr) begin
			nxt_bv = 1'b1; nxt_aw = 1'b0; nxt_w = 1'b0;
			nxt_br = (awa_ff == PCC_OFFSET || awa_ff == PORTCTL_OFFSET
				|| awa_ff == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bv_ff && s_axi_bready)
			nxt_bv = 1'b0;
		if (s_axi_arvalid && !rv_ff) begin
			nxt_rv = 1'b1; nxt_rr = RESP_OKAY;
			unique case (s_axi_araddr)
				PCC_OFFSET:     nxt_rd = {24'h0, pcc_read};
				PORTCTL_OFFSET: nxt_rd = {24'h0, portctl_ff};
				STATUS_OFFSET:  nxt_rd = {24'h0, own_ff, 1'b0, !debug_enable_pin_n_s,
					steal_ovr_ff, refused_ff};
				default: begin
					nxt_rd = 32'h0; nxt_rr = RESP_SLVERR;
				end
			endcase
		end else if (rv_ff && s_axi_rready)
			nxt_rv = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcc_on_ff <= PCC_RESET[PCC_ON_BIT];
			wu_ff <= PCC_RESET[1:0];
			portctl_ff <= PORTCTL_RESET; pfunc_ff <= '0;
			dbg_ff <= 1'b0; boot_ff <= 1'b1; pwe_ff <= 1'b1;
			refused_ff <= 1'b0; lclk_d_ff <= 1'b0;
			steal_cnt_ff <= '0; steal_ovr_ff <= 1'b0; own_ff <= DMB_IDLE;
			cpu_gnt_ff <= 1'b0; sdram_gnt_ff <= 1'b0; halt_ff <= 1'b0;
			aw_ff <= 1'b0; w_ff <= 1'b0; bv_ff <= 1'b0; rv_ff <= 1'b0;
			awa_ff <= '0; wd_ff <= '0; ws_ff <= '0; rd_ff <= '0;
			br_ff <= RESP_OKAY; rr_ff <= RESP_OKAY;
		end else begin
			pcc_on_ff <= nxt_pcc_on; wu_ff <= nxt_wu;
			portctl_ff <= nxt_portctl; pfunc_ff <= nxt_pfunc;
			dbg_ff <= nxt_dbg; boot_ff <= nxt_boot; pwe_ff <= nxt_pwe;
			refused_ff <= nxt_refused; lclk_d_ff <= nxt_lclk_d;
			steal_cnt_ff <= nxt_steal_cnt; steal_ovr_ff <= nxt_steal_ovr;
			own_ff <= nxt_own;
			cpu_gnt_ff <= nxt_cpu_gnt; sdram_gnt_ff <= nxt_sdram_gnt;
			halt_ff <= nxt_halt;
			aw_ff <= nxt_aw; w_ff <= nxt_w; bv_ff <= nxt_bv; rv_ff <= nxt_rv;
			awa_ff <= nxt_awa; wd_ff <= nxt_wd; ws_ff <= nxt_ws;
			rd_ff <= nxt_rd; br_ff <= nxt_br; rr_ff <= nxt_rr;
		end
	end

	assign steal_gnt           = own_ff == DMB_STEAL;
	assign disp_gnt            = own_ff == DMB_DISP;
	assign gdma_gnt            = own_ff == DMB_GDMA;
	assign sdram_gnt           = sdram_gnt_ff;
	assign cpu_gnt             = cpu_gnt_ff;
	assign cpu_halt            = halt_ff;
	assign debug_mode          = dbg_ff;
	assign boot_allowed        = boot_ff;
	assign power_enable_output = pwe_ff;
	assign warmup_sel          = wu_ff;
	assign dbg_pin_port_func   = pfunc_ff;
	assign s_axi_awready       = !aw_ff;
	assign s_axi_wready        = !w_ff;
	assign s_axi_bvalid        = bv_ff;
	assign s_axi_bresp         = br_ff;
	assign s_axi_arready       = !rv_ff;
	assign s_axi_rvalid        = rv_ff;
	assign s_axi_rdata         = rd_ff;
	assign s_axi_rresp         = rr_ff;
endmodule
`default_nettype wire

// file: tb/dmb_emu.sv
// Behavioural emulator: debug pin, boot straps and link clock
`timescale 1ns/1ps
`default_nettype none
module dmb_emu (
	// Control from the bench
	input  wire logic dbg,
	input  wire logic run,
	// Pins toward the device
	output logic      debug_enable_pin_n,
	output logic      boot_mode_select_0,
	output logic      boot_mode_select_1,
	output logic      debug_link_clock
);
	assign debug_enable_pin_n = !dbg;
	// Both straps high only outside debug
	assign boot_mode_select_0 = !dbg;
	assign boot_mode_select_1 = !dbg;
	// Link clock stands still outside frames
	initial begin
		debug_link_clock = 1'b0;
		forever #17 debug_link_clock = run ? !debug_link_clock : 1'b0;
	end
endmodule
`default_nettype wire

// file: tb/dmb_checker.sv
// Port assertions for the debug-mode bus arbiter
`timescale 1ns/1ps
`default_nettype none
module dmb_checker #(
	parameter int STEAL_MAX = 80
) (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Watched ports
	input wire logic       debug_link_clock,
	input wire logic       breakpoint_hit,
	input wire logic       disp_req,
	input wire logic       disp_done,
	input wire logic       gdma_done,
	input wire logic       steal_gnt,
	input wire logic       disp_gnt,
	input wire logic       gdma_gnt,
	input wire logic       cpu_halt,
	input wire logic       debug_mode,
	input wire logic       power_enable_output,
	input wire logic [8:0] dbg_pin_port_func
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       lclk_ff, nxt_lclk;
	logic [7:0] edges_ff, nxt_edges;
	// Raw pin edges lead the synchroniser, hence a slack of two
	always_comb begin
		nxt_lclk = debug_link_clock;
		nxt_edges = steal_gnt ? edges_ff + 8'(debug_link_clock && !lclk_ff) : 8'h00;
	end
	always_ff @(posedge aclk) begin
		lclk_ff <= aresetn & nxt_lclk;
		edges_ff <= aresetn ? nxt_edges : 8'h00;
	end
	sequence s_steal_end;
		steal_gnt && disp_req ##1 !steal_gnt;
	endsequence
	chk_power_kept: assert property (debug_mode |=> power_enable_output)
		else $error("power cut in debug");
	chk_grant_single: assert property ($onehot0({steal_gnt, disp_gnt, gdma_gnt}))
		else $error("two owners");
	chk_gdma_kept: assert property (gdma_gnt && !gdma_done |=> gdma_gnt)
		else $error("dma preempted");
	chk_disp_kept: assert property (disp_gnt && !disp_done |=> disp_gnt)
		else $error("display preempted");
	chk_disp_first: assert property (s_steal_end |-> !gdma_gnt [*2])
		else $error("dma ahead of display");
	chk_steal_bound: assert property (edges_ff <= STEAL_MAX + 2)
		else $error("steal hold too long");
	chk_halt_follows: assert property (breakpoint_hit && debug_mode |-> ##[1:4] cpu_halt)
		else $error("cpu not halted");
	chk_pins_held: assert property (debug_mode && $past(debug_mode)
		|-> dbg_pin_port_func == 9'h000) else $error("pin function changed");
endmodule
bind dmb_top dmb_checker #(.STEAL_MAX(STEAL_MAX)) chk_u (.*);
`default_nettype wire

// file: tb/dmb_top_tb.sv
// Self-checking bench for the debug-mode bus arbiter
`timescale 1ns/1ps
`default_nettype none
module dmb_top_tb
	import dmb_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, hot_resetn = 1'b1, dbg = 1'b0, run = 1'b0;
	logic        standby_req = 1'b0, breakpoint_hit = 1'b0, sdram_req = 1'b0, cpu_req = 1'b1;
	logic        steal_req, disp_req, gdma_req, steal_done, disp_done, gdma_done;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, warmup_sel;
	logic [8:0]  dbg_pin_port_func;
	logic        debug_enable_pin_n, boot_mode_select_0, boot_mode_select_1, debug_link_clock;
	logic        steal_gnt, disp_gnt, gdma_gnt, sdram_gnt, cpu_gnt, cpu_halt, debug_mode;
	logic        boot_allowed, power_enable_output, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          n_errors = 0, checks = 0;
	initial {steal_req, disp_req, gdma_req, steal_done, disp_done, gdma_done} = 6'h00;
	always #2.5 aclk = ~aclk;
	dmb_top #(.STEAL_MAX(4)) dut_u (.*);
	dmb_emu emu_u (.*);
	task automatic stop_test;
		if (n_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wt(const ref logic s, input logic v);
		// Limit stands for a line period stretched to absorb a steal hold
		for (int i = 0; i < 200 && s !== v; i++) @(posedge aclk);
		ck(32'(s), 32'(v));
	endtask
	// Requests are levels; a done strobe also drops the matching request
	task automatic req(input logic [2:0] m);
		@(posedge aclk) {steal_req, disp_req, gdma_req} <= {steal_req, disp_req, gdma_req} | m;
	endtask
	task automatic fin(input logic [2:0] m);
		@(posedge aclk) {steal_done, disp_done, gdma_done} <= m;
		{steal_req, disp_req, gdma_req} <= {steal_req, disp_req, gdma_req} & ~m;
		@(posedge aclk) {steal_done, disp_done, gdma_done} <= 3'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk) {s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) {r, s_axi_bready} <= {s_axi_bresp, 1'b0};
		end while (s_axi_bready);
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk) s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) {d, r, s_axi_rready} <= {s_axi_rdata, s_axi_rresp, 1'b0};
		end while (s_axi_rready);
	endtask
	task automatic t_regs;
		rd(PCC_OFFSET);
		ck(d, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(PCC_OFFSET, 32'h84 | k);
			rd(PCC_OFFSET);
			ck(d, 32'h80 | k);
			ck(32'(warmup_sel), k);
		end
		@(posedge aclk) hot_resetn <= 1'b0;
		@(posedge aclk) hot_resetn <= 1'b1;
		rd(PCC_OFFSET);
		ck(d, 32'h80);
		ck(32'(warmup_sel), 32'h0);
		rd(12'h300);
		ck(32'(r), 32'(RESP_SLVERR));
		wr(12'h300, 32'h0);
		ck(32'(r), 32'(RESP_SLVERR));
	endtask
	task automatic t_power;
		@(posedge aclk) standby_req <= 1'b1;
		wt(power_enable_output, 1'b0);
		@(posedge aclk) standby_req <= 1'b0;
		wt(power_enable_output, 1'b1);
		wr(PORTCTL_OFFSET, 32'h5a);
		ck(32'(r), 32'(RESP_OKAY));
		ck(32'(dbg_pin_port_func[7:0]), 32'h5a);
		@(posedge aclk) dbg <= 1'b1;
		wt(debug_mode, 1'b1);
		ck(32'(boot_allowed), 32'h1);
		@(posedge aclk) standby_req <= 1'b1;
		repeat (20) @(posedge aclk);
		ck(32'(power_enable_output), 32'h1);
		rd(STATUS_OFFSET);
		ck(32'(d[0]), 32'h1);
		@(posedge aclk) standby_req <= 1'b0;
		wr(PORTCTL_OFFSET, 32'ha5);
		rd(PORTCTL_OFFSET);
		ck(d, 32'ha5);
		ck(32'(dbg_pin_port_func), 32'h0);
	endtask
	task automatic t_arb;
		req(3'h4);
		wt(steal_gnt, 1'b1);
		req(3'h1);
		req(3'h2);
		repeat (3) @(posedge aclk);
		ck(32'({disp_gnt, gdma_gnt}), 32'h0);
		fin(3'h4);
		wt(disp_gnt, 1'b1);
		ck(32'(gdma_gnt), 32'h0);
		fin(3'h2);
		wt(gdma_gnt, 1'b1);
		req(3'h2);
		repeat (4) @(posedge aclk);
		ck(32'({disp_gnt, gdma_gnt}), 32'h1);
		fin(3'h1);
		wt(disp_gnt, 1'b1);
		fin(3'h2);
	endtask
	task automatic t_steal;
		@(posedge aclk) run <= 1'b1;
		req(3'h4);
		wt(steal_gnt, 1'b1);
		wt(steal_gnt, 1'b0);
		// The still-raised request is granted again; end that hold cleanly
		fin(3'h4);
		@(posedge aclk) run <= 1'b0;
		rd(STATUS_OFFSET);
		ck(32'(d[1]), 32'h1);
		ck(32'(cpu_gnt), 32'h1);
		wr(STATUS_OFFSET, 32'h3);
		rd(STATUS_OFFSET);
		ck(32'(d[1:0]), 32'h0);
		@(posedge aclk) breakpoint_hit <= 1'b1;
		@(posedge aclk) breakpoint_hit <= 1'b0;
		wt(cpu_halt, 1'b1);
		@(posedge aclk) sdram_req <= 1'b1;
		ck(32'(cpu_gnt), 32'h0);
		wt(sdram_gnt, 1'b1);
		@(posedge aclk) sdram_req <= 1'b0;
		req(3'h2);
		wt(disp_gnt, 1'b1);
		fin(3'h2);
	endtask
	task automatic t_exit;
		@(posedge aclk) dbg <= 1'b0;
		wt(debug_mode, 1'b0);
		// Pin reset only once the debug session is over
		@(posedge aclk) aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(PCC_OFFSET);
		ck(d, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_regs;
		t_power;
		t_arb;
		t_steal;
		t_exit;
		stop_test;
	end
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
